// *** verilog/osd_pkg.sv ***
/*
  Shared constants and types for the display line interrupt unit and
  the display memory access port. Assumes a 32-bit APB register bus.
*/
`default_nettype none
package osd_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_LINE_IRQ = 8'h00;
  localparam logic [7:0] OFS_ADDR_MSB = 8'h04;
  localparam logic [7:0] OFS_ADDR_LOW = 8'h08;
  localparam logic [7:0] OFS_CODE_MSB = 8'h0c;
  localparam logic [7:0] OFS_CODE_LOW = 8'h10;
  localparam logic [7:0] OFS_ATTR     = 8'h14;
  localparam logic [7:0] OFS_MISC     = 8'h18;

  // Field positions
  localparam int IRQ_SEL_BIT   = 4;
  localparam int MISC_RMW_BIT  = 0;
  localparam int MISC_BANK_BIT = 1;
  localparam int MISC_RDIR_BIT = 2;

  // Values after reset, and the line count limit
  localparam logic [3:0] RST_LINE_MATCH = 4'h0;
  localparam logic       RST_IRQ_SEL    = 1'b0;
  localparam logic [8:0] RST_ADDR       = 9'h000;
  localparam logic       RST_CODE_MSB   = 1'b0;
  localparam logic [3:0] RST_LINE_COUNT = 4'h0;
  localparam logic [3:0] LINE_COUNT_MAX = 4'hf;

  // Synchroniser depth for the sync inputs
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic rsvd;
    logic attr_italic;
    logic attr_underline;
    logic attr_blink;
    logic attr_bg_enable;
    logic attr_red;
    logic attr_green;
    logic attr_blue;
  } attr_t;

  localparam attr_t RST_ATTR = attr_t'(8'h00);

  typedef struct packed {
    logic [8:0] code;
    attr_t      attr;
  } cell_t;

  typedef struct packed {
    logic read_dir_sel;
    logic bank_both_sel;
    logic rmw_mode;
  } misc_t;

  localparam misc_t RST_MISC = misc_t'(3'h0);

  typedef enum {ACC_IDLE, ACC_ANSWER} apb_state_t;

  // Strip the reserved attribute bit
  function automatic attr_t clean_attr(input logic [7:0] v);
    attr_t a;
    a = attr_t'(v);
    a.rsvd = 1'b0;
    return a;
  endfunction

endpackage
`default_nettype wire

// *** verilog/sync_fall_detect.sv ***
/*
  Two-stage synchroniser with falling edge pulse for an active-low sync.
  Assumes the input is asynchronous to clk_sys and held for >2 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module sync_fall_detect
  import osd_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic sync_n,
  output var  logic fall
);

  logic [SYNC_STAGES-1:0] stage_q;
  logic                   prev_q;

  // Only the last stage feeds the edge detector
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage_q <= '1;
      prev_q  <= 1'b1;
    end else if (ce) begin
      stage_q <= {stage_q[SYNC_STAGES-2:0], sync_n};
      prev_q  <= stage_q[SYNC_STAGES-1];
    end
  end

  assign fall = prev_q & ~stage_q[SYNC_STAGES-1];

endmodule
`default_nettype wire

// *** verilog/vram_array.sv ***
/*
  Display memory: one write port with separate code and attribute
  enables, two asynchronous read ports (processor and display).
*/
`timescale 1ns/1ps
`default_nettype none
module vram_array
  import osd_pkg::*;
#(
  parameter int ADDR_W = 9
) (
  input  wire logic              clk_sys,
  input  wire logic              ce,
  input  wire logic              we_code,
  input  wire logic              we_attr,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire cell_t             wdata,
  input  wire logic [ADDR_W-1:0] raddr_a,
  output var  cell_t             rdata_a,
  input  wire logic [ADDR_W-1:0] raddr_b,
  output var  cell_t             rdata_b
);

  cell_t mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk_sys) begin
    if (ce && we_code) begin
      mem[waddr].code <= wdata.code;
    end
    if (ce && we_attr) begin
      mem[waddr].attr <= wdata.attr;
    end
  end

  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];

endmodule
`default_nettype wire

// *** verilog/osd_line_irq_and_vram_port.sv ***
/*
  Display line counter with interrupt generator, and the processor
  port into display memory, as an APB slave. Assumes sync inputs are
  asynchronous active-low levels and a 32-bit APB master.
*/
// Chosen here: the address map and the APB slave port.
// Functional notes
// - Four-bit line count, cleared by vsync fall
// - Count is binary completed lines, up to fifteen
// - Source select bit 4: vsync or line match
// - Match value zero means at count clear
// - Nine-bit address register selects memory cell
// - Control and data writes take effect immediately
// - Bank bit 1 selects single or dual transfer
// - Code low write commits nine bits, advances
// - Single-bank attribute write commits and advances
// - Dual-bank attribute write holds address until code
// - Normal single-bank reads advance after code low and attribute reads
// - Dual-bank reads advance only on code low
// - Modify mode reads hold, writes still advance
// - Code low combines with last stored msb
`timescale 1ns/1ps
`default_nettype none
module osd_line_irq_and_vram_port
  import osd_pkg::*;
#(
  parameter int ADDR_W = 9,
  parameter int LINE_W = 4
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic              vertical_sync_n,
  input  wire logic              horizontal_sync_n,
  output var  logic              irq_pulse,
  input  wire logic [ADDR_W-1:0] disp_addr,
  output var  cell_t             disp_cell
);

  if (ADDR_W != 9 || LINE_W != 4) begin : g_check
    $error("osd_line_irq_and_vram_port supports only ADDR_W=9 and LINE_W=4");
  end

  // Sync edges
  logic v_fall;
  logic h_fall;

  sync_fall_detect u_vsync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .sync_n  (vertical_sync_n),
    .fall    (v_fall)
  );

  sync_fall_detect u_hsync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .sync_n  (horizontal_sync_n),
    .fall    (h_fall)
  );

  // Line counter and interrupt
  logic [3:0] line_count_q;
  logic [3:0] irq_line_match_q;
  logic       irq_source_sel_q;
  logic       irq_q;

  wire        line_full  = (line_count_q == LINE_COUNT_MAX);
  wire        line_step  = h_fall & ~v_fall & ~line_full;
  wire  [3:0] line_next  = line_count_q + 4'h1;
  wire        match_vs   = v_fall & (irq_line_match_q == 4'h0);
  wire        match_line = line_step & (line_next == irq_line_match_q);
  wire        irq_d      = irq_source_sel_q ? v_fall : (match_vs | match_line);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      line_count_q <= RST_LINE_COUNT;
      irq_q        <= 1'b0;
    end else if (ce) begin
      if (v_fall) begin
        line_count_q <= RST_LINE_COUNT;
      end else if (line_step) begin
        line_count_q <= line_next;
      end
      irq_q <= irq_d;
    end
  end

  // APB handshake
  apb_state_t state_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  wire setup    = psel & ~penable & (state_q == ACC_IDLE);
  wire acc_fire = psel & penable & (state_q == ACC_ANSWER);
  wire wr_fire  = acc_fire & pwrite;
  wire rd_fire  = acc_fire & ~pwrite;

  wire sel_line = (paddr == OFS_LINE_IRQ);
  wire sel_amsb = (paddr == OFS_ADDR_MSB);
  wire sel_alow = (paddr == OFS_ADDR_LOW);
  wire sel_cmsb = (paddr == OFS_CODE_MSB);
  wire sel_clow = (paddr == OFS_CODE_LOW);
  wire sel_attr = (paddr == OFS_ATTR);
  wire sel_misc = (paddr == OFS_MISC);
  wire hit      = sel_line | sel_amsb | sel_alow | sel_cmsb | sel_clow | sel_attr | sel_misc;

  // Memory access state
  logic [ADDR_W-1:0] addr_q;
  logic              code_msb_q;
  attr_t             attr_stage_q;
  misc_t             misc_q;
  cell_t             cpu_cell;
  cell_t             wcell;
  cell_t             disp_cell_w;
  cell_t             disp_cell_q;

  wire rdir = misc_q.read_dir_sel;
  wire bank = misc_q.bank_both_sel;
  wire rmw  = misc_q.rmw_mode;

  wire code_wr = wr_fire & sel_clow & ~rdir;
  wire attr_wr = wr_fire & sel_attr & ~rdir;
  wire code_rd = rd_fire & sel_clow & rdir;
  wire attr_rd = rd_fire & sel_attr & rdir;

  // Address advance: code and single-bank attribute transfers, reads only outside modify mode
  wire adv = code_wr | (attr_wr & ~bank)
           | (code_rd & ~rmw)
           | (attr_rd & ~rmw & ~bank);

  wire [ADDR_W-1:0] addr_inc = addr_q + 9'h001;

  // Nine code bits from the stored msb and written low byte
  assign wcell.code = {code_msb_q, pwdata[7:0]};
  assign wcell.attr = (code_wr & bank) ? attr_stage_q : clean_attr(pwdata[7:0]);

  wire we_code = code_wr;
  wire we_attr = attr_wr | (code_wr & bank);

  vram_array #(
    .ADDR_W (ADDR_W)
  ) u_vram (
    .clk_sys (clk_sys),
    .ce      (ce),
    .we_code (we_code),
    .we_attr (we_attr),
    .waddr   (addr_q),
    .wdata   (wcell),
    .raddr_a (addr_q),
    .rdata_a (cpu_cell),
    .raddr_b (disp_addr),
    .rdata_b (disp_cell_w)
  );

  // Read data selection
  wire [31:0] rd_line = {27'h0, irq_source_sel_q, line_count_q};
  wire [31:0] rd_amsb = {31'h0, addr_q[8]};
  wire [31:0] rd_alow = {24'h0, addr_q[7:0]};
  wire [31:0] rd_cmsb = {31'h0, cpu_cell.code[8]};
  wire [31:0] rd_clow = {24'h0, cpu_cell.code[7:0]};
  wire [31:0] rd_attr = {24'h0, cpu_cell.attr};
  wire [31:0] rd_misc = {29'h0, misc_q};
  wire [31:0] rd_data = sel_line ? rd_line :
                        sel_amsb ? rd_amsb :
                        sel_alow ? rd_alow :
                        sel_cmsb ? rd_cmsb :
                        sel_clow ? rd_clow :
                        sel_attr ? rd_attr :
                        sel_misc ? rd_misc : 32'h0;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q   <= ACC_IDLE;
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      case (state_q)
        ACC_IDLE: begin
          if (setup) begin
            state_q   <= ACC_ANSWER;
            prdata_q  <= pwrite ? 32'h0 : rd_data;
            pready_q  <= 1'b1;
            pslverr_q <= ~hit;
          end
        end
        ACC_ANSWER: begin
          if (acc_fire) begin
            state_q   <= ACC_IDLE;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
          end
        end
        default: begin
          state_q <= ACC_IDLE;
        end
      endcase
    end
  end

  // Register writes take effect at the access edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_source_sel_q <= RST_IRQ_SEL;
      irq_line_match_q <= RST_LINE_MATCH;
      addr_q           <= RST_ADDR;
      code_msb_q       <= RST_CODE_MSB;
      attr_stage_q     <= RST_ATTR;
      misc_q           <= RST_MISC;
    end else if (ce) begin
      if (wr_fire && sel_line) begin
        irq_source_sel_q <= pwdata[IRQ_SEL_BIT];
        irq_line_match_q <= pwdata[3:0];
      end
      if (wr_fire && sel_misc) begin
        misc_q.rmw_mode      <= pwdata[MISC_RMW_BIT];
        misc_q.bank_both_sel <= pwdata[MISC_BANK_BIT];
        misc_q.read_dir_sel  <= pwdata[MISC_RDIR_BIT];
      end
      if (wr_fire && sel_cmsb) begin
        code_msb_q <= pwdata[0];
      end
      if (attr_wr) begin
        attr_stage_q <= clean_attr(pwdata[7:0]);
      end
      if (wr_fire && sel_amsb) begin
        addr_q[8] <= pwdata[0];
      end else if (wr_fire && sel_alow) begin
        addr_q[7:0] <= pwdata[7:0];
      end else if (adv) begin
        addr_q <= addr_inc;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      disp_cell_q <= cell_t'(17'h0);
    end else if (ce) begin
      disp_cell_q <= disp_cell_w;
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign irq_pulse = irq_q;
  assign disp_cell = disp_cell_q;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_line_clear: assert property (ce && v_fall |=> line_count_q == 4'h0)
    else $error("line count not cleared by vsync");
  chk_line_step: assert property (ce && line_step |=> line_count_q == $past(line_count_q) + 4'h1)
    else $error("line count did not advance");
  chk_vsync_irq: assert property (ce && irq_source_sel_q && v_fall |=> irq_q)
    else $error("no interrupt on vsync");
  chk_match_irq: assert property (ce && !irq_source_sel_q && line_step
      && line_next == irq_line_match_q && irq_line_match_q != 4'h0 |=> irq_q)
    else $error("no interrupt at matching line");
  chk_irq_pulse: assert property (ce && irq_q |=> !irq_q)
    else $error("interrupt longer than one cycle");
  chk_addr_load: assert property (ce && wr_fire && sel_alow |=> addr_q[7:0] == $past(pwdata[7:0]))
    else $error("address low byte not loaded");
  chk_code_advance: assert property (ce && code_wr |=> addr_q == $past(addr_inc))
    else $error("code write did not advance address");
  chk_single_attr: assert property (ce && attr_wr && !bank |=> addr_q == $past(addr_inc))
    else $error("single-bank attribute write did not advance");
  chk_dual_attr: assert property (ce && attr_wr && bank |=> $stable(addr_q))
    else $error("dual-bank attribute write moved address");
  chk_dual_read: assert property (ce && attr_rd && bank |=> $stable(addr_q))
    else $error("dual-bank attribute read moved address");
  chk_rmw_hold: assert property (ce && rmw && (code_rd || attr_rd) |=> $stable(addr_q))
    else $error("modify-mode read moved address");
  chk_read_adv: assert property (ce && code_rd && !rmw |=> addr_q == $past(addr_inc))
    else $error("normal read did not advance");
  chk_apb_answer: assert property (ce && setup |=> pready_q ##1 !pready_q || !ce)
    else $error("APB answer not one cycle");

  cov_vsync_irq: cover property (irq_source_sel_q && irq_q);
  cov_match_irq: cover property (ce && match_line);
  cov_dual_code: cover property (ce && code_wr && bank);
  cov_rmw_cycle: cover property (ce && attr_rd && rmw ##[1:20] attr_wr);

endmodule
`default_nettype wire

// *** verif/sync_source.sv ***
/*
  Behavioural source of the active-low vertical and horizontal sync lines.
  Assumes calls do not overlap; each pulse carries its own spacing; lines idle high between pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module sync_source (
  output var logic vertical_sync_n,
  output var logic horizontal_sync_n
);
  initial begin
    vertical_sync_n = 1'b1;
    horizontal_sync_n = 1'b1;
  end

  // Asynchronous pulse, each level held well over three clocks
  task automatic pulse(input logic vert);
    #3;
    if (vert) vertical_sync_n = 1'b0;
    else horizontal_sync_n = 1'b0;
    #70;
    vertical_sync_n = 1'b1;
    horizontal_sync_n = 1'b1;
    #67;
  endtask
endmodule
`default_nettype wire

// *** verif/tb_osd_line_irq_and_vram_port.sv ***
/*
  Self-checking bench: APB master, line counter and interrupt trials,
  display memory access modes against a bench model. Assumes one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_osd_line_irq_and_vram_port;
  import osd_pkg::*;
  logic        clk_sys, rst, ce, psel, penable, pwrite, perr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, irq_pulse, sel;
  wire logic   vsn, hsn;
  logic [8:0]  disp_addr, ea, a, c;
  cell_t       disp_cell;
  cell_t       mem [512];
  misc_t       em;
  attr_t       stg;
  logic        cm;
  logic [3:0]  m;
  logic [7:0]  t;
  logic [15:0] lf;
  int mismatches, comparisons, irqs, cyc, i, j, k;

  osd_line_irq_and_vram_port osd_line_irq_and_vram_port_inst (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .vertical_sync_n(vsn),
    .horizontal_sync_n(hsn), .irq_pulse(irq_pulse), .disp_addr(disp_addr),
    .disp_cell(disp_cell));
  sync_source sync_source_inst (.vertical_sync_n(vsn), .horizontal_sync_n(hsn));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (irq_pulse === 1'b1) irqs++;
    if (cyc == 30000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // One word per transfer, idle cycle between transfers
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic adv(input logic w, input logic [7:0] o);
    if (w && em.read_dir_sel) return 1'b0;
    if (!w && (!em.read_dir_sel || em.rmw_mode)) return 1'b0;
    if (o == OFS_CODE_LOW) return 1'b1;
    return o == OFS_ATTR && !em.bank_both_sel;
  endfunction

  function automatic logic [3:0] cnt_of(input int n);
    return n > 15 ? 4'hf : 4'(n);
  endfunction

  // Data-port access, with the bench model of memory and address
  task automatic dp(input logic w, input logic [7:0] o, input logic [7:0] d);
    logic [31:0] q;
    logic        ad;
    ad = adv(w, o);
    apb(w, o, {24'h0, d}, q);
    if (w && !em.read_dir_sel) begin
      if (o == OFS_CODE_MSB) cm = d[0];
      if (o == OFS_CODE_LOW) mem[ea].code = {cm, d};
      if (o == OFS_CODE_LOW && em.bank_both_sel) mem[ea].attr = stg;
      if (o == OFS_ATTR) stg = attr_t'(d & 8'h7f);
      if (o == OFS_ATTR) mem[ea].attr = stg;
    end
    if (!w && o == OFS_CODE_MSB) check(q[0], mem[ea].code[8]);
    if (!w && o == OFS_CODE_LOW) check(q[7:0], mem[ea].code[7:0]);
    if (!w && o == OFS_ATTR) check(q[7:0], mem[ea].attr);
    if (w && o == OFS_MISC) em = misc_t'(d[2:0]);
    if (w && o == OFS_ADDR_MSB) ea[8] = d[0];
    if (w && o == OFS_ADDR_LOW) ea[7:0] = d;
    if (ad) ea = ea + 9'h001;
  endtask

  task automatic seta(input logic [8:0] x);
    dp(1'b1, OFS_ADDR_MSB, {7'h0, x[8]});
    dp(1'b1, OFS_ADDR_LOW, x[7:0]);
  endtask

  task automatic chk_addr();
    logic [31:0] h, l;
    apb(1'b0, OFS_ADDR_MSB, 32'h0, h);
    apb(1'b0, OFS_ADDR_LOW, 32'h0, l);
    check({h[0], l[7:0]}, ea);
  endtask

  // Display read holds the old cell while ce is low, then shows the new one
  task automatic chk_cell(input logic [8:0] x);
    logic [8:0] p;
    p = disp_addr;
    ce <= 1'b0;
    disp_addr <= x;
    repeat (2) @(posedge clk_sys);
    check({15'h0, disp_cell}, {15'h0, mem[p]});
    ce <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check({15'h0, disp_cell}, {15'h0, mem[x]});
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    disp_addr = 9'h000;
    lf = 16'h1a15;
    em = RST_MISC;
    ea = RST_ADDR;
    cm = RST_CODE_MSB;
    stg = RST_ATTR;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, OFS_LINE_IRQ, 32'h0, r);
    check(r, 32'h0);
    apb(1'b0, OFS_MISC, 32'h0, r);
    check(r, 32'h0);
    chk_addr();
    apb(1'b1, 8'h1c, 32'h5a, r);
    check(perr, 1'b1);
    apb(1'b0, 8'h1c, 32'h0, r);
    check(perr, 1'b1);
    check(r, 32'h0);
    // Interrupt source and line match trials, one saturating
    for (i = 0; i < 10; i++) begin
      lf = lfsr(lf);
      sel = lf[4];
      m = lf[3:0];
      k = i == 0 ? 17 : (i < 5 ? int'(m) : int'(lf[10:7]));
      dp(1'b1, OFS_LINE_IRQ, {3'h0, sel, m});
      irqs = 0;
      sync_source_inst.pulse(1'b1);
      for (j = 0; j < k; j++) sync_source_inst.pulse(1'b0);
      repeat (5) @(posedge clk_sys);
      // Count read only while the syncs are quiet
      apb(1'b0, OFS_LINE_IRQ, 32'h0, r);
      check(r[4:0], {sel, cnt_of(k)});
      check(irqs, (sel || m == 4'h0 || m <= cnt_of(k)) ? 1 : 0);
    end
    // Fill all cells in dual-bank mode, address wraps at the top
    dp(1'b1, OFS_MISC, 8'h02);
    seta(9'h000);
    for (j = 0; j < 512; j++) begin
      dp(1'b1, OFS_ATTR, 8'h00);
      dp(1'b1, OFS_CODE_MSB, {7'h0, j[8]});
      dp(1'b1, OFS_CODE_LOW, j[7:0]);
    end
    for (i = 0; i < 6; i++) begin
      lf = lfsr(lf);
      a = i == 0 ? 9'h1ff : lf[8:0];
      lf = lfsr(lf);
      c = lf[8:0];
      t = lf[15:8];
      // Display side looks far from the cells being updated
      disp_addr <= a + 9'h100;
      dp(1'b1, OFS_MISC, 8'h00);
      seta(a);
      dp(1'b1, OFS_CODE_MSB, {7'h0, c[8]});
      dp(1'b1, OFS_CODE_LOW, c[7:0]);
      dp(1'b1, OFS_ATTR, t);
      dp(1'b1, OFS_CODE_LOW, ~c[7:0]);
      dp(1'b1, OFS_MISC, 8'h02);
      dp(1'b1, OFS_ATTR, ~t);
      dp(1'b1, OFS_CODE_MSB, {7'h0, ~c[8]});
      dp(1'b1, OFS_CODE_LOW, t);
      dp(1'b1, OFS_MISC, 8'h04);
      seta(a);
      dp(1'b0, OFS_CODE_MSB, 8'h00);
      dp(1'b0, OFS_CODE_LOW, 8'h00);
      dp(1'b0, OFS_ATTR, 8'h00);
      dp(1'b1, OFS_MISC, 8'h06);
      dp(1'b0, OFS_ATTR, 8'h00);
      dp(1'b0, OFS_CODE_MSB, 8'h00);
      dp(1'b0, OFS_CODE_LOW, 8'h00);
      dp(1'b1, OFS_MISC, 8'h05);
      dp(1'b0, OFS_ATTR, 8'h00);
      dp(1'b0, OFS_CODE_LOW, 8'h00);
      dp(1'b1, OFS_CODE_LOW, c[7:0]);
      dp(1'b1, OFS_MISC, 8'h01);
      dp(1'b1, OFS_ATTR, t ^ 8'h55);
      chk_addr();
      for (j = 0; j < 4; j++) chk_cell(a + 9'(j));
    end
    end_of_test();
  end
endmodule
`default_nettype wire
